// file: sim/testbench.sv
// Purpose: self-checking bench for the status flag and arithmetic core
// Assumes: high-speed tick unless a test picks middle speed
// Notes:   rows hold ordinary ops; reset, timing and side registers by hand
`timescale 1ns/10ps
`default_nettype none
module testbench;
  typedef struct packed {
    csf_pkg::csf_op_type op;
    logic [7:0] a, b, lo, hi, ps, psm;
    logic [1:0] chk;
  } csf_row_type;
  // clock, reset and stimulus
  logic                   core_clk;
  logic                   rst;
  logic                   opValid;
  csf_pkg::csf_op_type    opCode;
  logic [3:0]             opCycles;
  logic [7:0]             opA;
  logic [7:0]             opB;
  csf_pkg::csf_speed_type speedMode;
  logic                   irqWrite;
  logic [7:0]             irqWriteData;
  logic                   dirWrite;
  logic [7:0]             dirWriteData;
  logic                   dirRead;
  // observed outputs
  logic                   opBusy;
  logic                   opDone;
  logic [7:0]             resultLo;
  logic [7:0]             resultHi;
  logic [7:0]             processor_status_word;
  logic [7:0]             irqVisible;
  logic [7:0]             dirValue;
  logic [7:0]             dirReadData;
  int                     miscompares;
  int                     total_checks;
  int                     n;
  // ordinary ops: op, a, b, lo, hi, status, status mask, lo/hi check
  csf_row_type rows [19] = '{
    '{csf_pkg::CSF_OP_CLRC, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'hFF, 2'd0},
    '{csf_pkg::CSF_OP_CLRD, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'hFF, 2'd0},
    '{csf_pkg::CSF_OP_ADC, 8'h50, 8'h50, 8'hA0, 8'h00, 8'hC4, 8'hFF, 2'd1},
    '{csf_pkg::CSF_OP_ADC, 8'hFF, 8'h01, 8'h00, 8'h00, 8'h07, 8'hFF, 2'd1},
    '{csf_pkg::CSF_OP_SUBC, 8'h10, 8'h20, 8'hF0, 8'h00, 8'h84, 8'hFF, 2'd1},
    '{csf_pkg::CSF_OP_MULT, 8'h12, 8'h34, 8'hA8, 8'h03, 8'h84, 8'hFF, 2'd3},
    '{csf_pkg::CSF_OP_DIV, 8'h64, 8'h07, 8'h0E, 8'h02, 8'h84, 8'hFF, 2'd3},
    '{csf_pkg::CSF_OP_SET, 8'h00, 8'h00, 8'h00, 8'h00, 8'hA4, 8'hFF, 2'd0},
    '{csf_pkg::CSF_OP_SED, 8'h00, 8'h00, 8'h00, 8'h00, 8'hAC, 8'hFF, 2'd0},
    '{csf_pkg::CSF_OP_MULT, 8'h12, 8'h34, 8'hA8, 8'h03, 8'hAC, 8'hFF, 2'd3},
    '{csf_pkg::CSF_OP_DIV, 8'h64, 8'h07, 8'h0E, 8'h02, 8'hAC, 8'hFF, 2'd3},
    '{csf_pkg::CSF_OP_DIV, 8'h55, 8'h00, 8'hFF, 8'h55, 8'hAC, 8'hFF, 2'd3},
    '{csf_pkg::CSF_OP_SETC, 8'h00, 8'h00, 8'h00, 8'h00, 8'hAD, 8'hFF, 2'd0},
    '{csf_pkg::CSF_OP_ADC, 8'h45, 8'h38, 8'h84, 8'h00, 8'h2C, 8'h3D, 2'd1},
    '{csf_pkg::CSF_OP_CLT, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0C, 8'h3D, 2'd0},
    '{csf_pkg::CSF_OP_SUBC, 8'h42, 8'h15, 8'h26, 8'h00, 8'h0D, 8'h3D, 2'd1},
    '{csf_pkg::CSF_OP_SUBC, 8'h10, 8'h20, 8'h90, 8'h00, 8'h0C, 8'h3D, 2'd1},
    '{csf_pkg::CSF_OP_MULT, 8'h99, 8'h99, 8'h71, 8'h5B, 8'h0C, 8'h3D, 2'd3},
    '{csf_pkg::CSF_OP_CLRD, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h3D, 2'd0}
  };

  csf_core #(.CYC_W(4)) csf_core_inst (
    .core_clk(core_clk), .rst(rst), .opValid(opValid), .opCode(opCode),
    .opCycles(opCycles), .opA(opA), .opB(opB), .speedMode(speedMode),
    .irqWrite(irqWrite), .irqWriteData(irqWriteData), .dirWrite(dirWrite),
    .dirWriteData(dirWriteData), .dirRead(dirRead), .opBusy(opBusy),
    .opDone(opDone), .resultLo(resultLo), .resultHi(resultHi),
    .processor_status_word(processor_status_word), .irqVisible(irqVisible),
    .dirValue(dirValue), .dirReadData(dirReadData)
  );

  // 50 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // verdict and end of run
  task end_sim;
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  // byte compare
  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // one op, returns edges from take to the done pulse
  task run_op(input csf_pkg::csf_op_type op, input logic [7:0] a, input logic [7:0] b,
              input logic [3:0] cyc, output int cnt);
    @(posedge core_clk);
    #1;
    opValid = 1'b1;
    opCode = op;
    opA = a;
    opB = b;
    opCycles = cyc;
    @(posedge core_clk);
    #1;
    opValid = 1'b0;
    cnt = 1;
    while (opDone !== 1'b1 && cnt < 60) begin
      @(posedge core_clk);
      #1;
      cnt++;
    end
    if (opDone !== 1'b1) begin
      miscompares++;
      end_sim();
    end
  endtask : run_op

  // reset for two cycles
  task do_reset;
    rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    rst = 1'b0;
  endtask : do_reset

  // main sequence
  initial begin
    miscompares = 0;
    total_checks = 0;
    {opValid, irqWrite, dirWrite, dirRead} = '0;
    opCode = csf_pkg::CSF_OP_NONE;
    {opCycles, opA, opB, irqWriteData, dirWriteData} = '0;
    speedMode = csf_pkg::CSF_SPD_HIGH;
    do_reset();
    chk("statusAtReset", 8'h04, processor_status_word);
    chk("irqAtReset", 8'h00, irqVisible);
    foreach (rows[i]) begin
      run_op(rows[i].op, rows[i].a, rows[i].b, 4'd1, n);
      chk("status", rows[i].ps, processor_status_word & rows[i].psm);
      if (rows[i].chk[0]) chk("resultLo", rows[i].lo, resultLo);
      if (rows[i].chk[1]) chk("resultHi", rows[i].hi, resultHi);
    end
    // instruction length in both speed modes
    run_op(csf_pkg::CSF_OP_SETT, 8'h00, 8'h00, 4'd3, n);
    chk("highLength", 8'd4, n[7:0]);
    chk("settStatus", 8'h24, processor_status_word & 8'h3D);
    run_op(csf_pkg::CSF_OP_SETT, 8'h00, 8'h00, 4'd2, n);
    chk("highLength2", 8'd3, n[7:0]);
    speedMode = csf_pkg::CSF_SPD_MID;
    run_op(csf_pkg::CSF_OP_CLT, 8'h00, 8'h00, 4'd3, n);
    chk("midLength", 8'd1, {7'd0, n >= 9 && n <= 13});
    speedMode = csf_pkg::CSF_SPD_HIGH;
    // request bits appear only after a later instruction
    @(posedge core_clk);
    #1;
    irqWrite = 1'b1;
    irqWriteData = 8'hA5;
    @(posedge core_clk);
    #1;
    irqWrite = 1'b0;
    chk("irqEarly", 8'h00, irqVisible);
    run_op(csf_pkg::CSF_OP_SETC, 8'h00, 8'h00, 4'd1, n);
    chk("irqAtDone", 8'h00, irqVisible);
    @(posedge core_clk);
    #1;
    chk("irqLate", 8'hA5, irqVisible);
    // direction register is write-only
    dirWrite = 1'b1;
    dirWriteData = 8'h3C;
    @(posedge core_clk);
    #1;
    dirWrite = 1'b0;
    dirRead = 1'b1;
    @(posedge core_clk);
    #1;
    dirRead = 1'b0;
    chk("dirValue", 8'h3C, dirValue);
    chk("dirReadData", 8'h00, dirReadData);
    // second reset in mid-run
    do_reset();
    chk("statusReset2", 8'h04, processor_status_word);
    chk("dirReset2", 8'h00, dirValue);
    end_sim();
  end
endmodule : testbench
`default_nettype wire

// file: verilog/csf_addsub.sv
// Purpose: binary and packed-bcd add and subtract with carry
// Assumes: operands are valid bcd when decimal mode is on
// Notes:   carry in on subtract means no borrow
`timescale 1ns/10ps
`default_nettype none
`include "csf_defines.svh"
module csf_addsub (
  csf_alu_if.unit alu
);
  logic [8:0] binSum;
  logic [7:0] opBx;
  logic [4:0] loSum;
  logic [8:0] decSum;
  logic [7:0] decDiff;
  logic       loBorrow;
  logic       hiBorrow;

  // binary path, subtract uses inverted operand
  always_comb begin
    opBx   = alu.isSub ? ~alu.opB : alu.opB;
    binSum = {1'b0, alu.opA} + {1'b0, opBx} + {8'h00, alu.carryIn};
  end

  // decimal add: nibble correction by six
  always_comb begin
    loSum  = {1'b0, alu.opA[3:0]} + {1'b0, alu.opB[3:0]} + {4'h0, alu.carryIn};
    decSum = {1'b0, alu.opA[7:4], 4'h0} + {1'b0, alu.opB[7:4], 4'h0};
    if (loSum > 5'h09) begin
      loSum = loSum + 5'(`CSF_BCD_ADJ);
    end
    decSum = decSum + {4'h0, loSum};
    if (decSum[8:4] > 5'h09) begin
      decSum = decSum + {1'b0, `CSF_BCD_ADJ_HI};
    end
  end

  // decimal subtract: borrow per nibble, correct by six
  always_comb begin
    loBorrow = ({1'b0, alu.opA[3:0]}) < ({1'b0, alu.opB[3:0]} + {4'h0, ~alu.carryIn});
    hiBorrow = binSum[8] == 1'b0;
    decDiff  = binSum[7:0];
    if (loBorrow) begin
      decDiff = decDiff - `CSF_BCD_ADJ;
    end
    if (hiBorrow) begin
      decDiff = decDiff - `CSF_BCD_ADJ_HI;
    end
  end

  // result select [RQ4] [RQ12]
  always_comb begin
    alu.overflow = (alu.opA[7] == opBx[7]) && (binSum[7] != alu.opA[7]);
    if (alu.decimalMode && !alu.isSub) begin
      alu.result   = decSum[7:0];
      alu.carryOut = decSum[8];
    end else if (alu.decimalMode) begin
      alu.result   = decDiff;
      alu.carryOut = binSum[8];
    end else begin
      alu.result   = binSum[7:0];
      alu.carryOut = binSum[8];
    end
  end
endmodule : csf_addsub
`default_nettype wire

// file: verilog/csf_alu_if.sv
// Purpose: carries operands and results between core and arithmetic unit
// Assumes: single clock, combinational unit
// Notes:   none
`timescale 1ns/10ps
`default_nettype none
interface csf_alu_if;
  logic       isSub;
  logic       decimalMode;
  logic [7:0] opA;
  logic [7:0] opB;
  logic       carryIn;
  logic [7:0] result;
  logic       carryOut;
  logic       overflow;
  modport core (output isSub, decimalMode, opA, opB, carryIn,
                input result, carryOut, overflow);
  modport unit (input isSub, decimalMode, opA, opB, carryIn,
                output result, carryOut, overflow);
endinterface : csf_alu_if
`default_nettype wire

// file: verilog/csf_core.sv
// Purpose: status word, decimal arithmetic, multiply/divide, request bits
// Assumes: software sequences instructions; one op per accepted cycle
// Notes:   see behaviour notes below
// Notes on behaviour
// RQ1 - reset sets the interrupt-disable flag and leaves other flags at a fixed don't-care value.
// RQ2 - software must set the index-x-mode and decimal flags itself after reset.
// RQ3 - a written request value becomes visible only after a later instruction.
// RQ4 - with decimal flag set only add and subtract with carry give packed-bcd results.
// RQ5 - software waits one instruction after add/subtract before carry or decimal ops.
// RQ6 - negative, overflow and zero are not meaningful in decimal mode.
// RQ7 - multiply and divide ignore the index-x-mode and decimal flags.
// RQ8 - multiply and divide leave the status word untouched.
// RQ9 - direction registers are write-only and read back as zero.
// RQ10 - software writes direction registers only with pure writes.
// RQ11 - an instruction takes its cycle count times the system clock period.
// RQ12 - with decimal flag clear add and subtract are binary and update n, v, z, c.
`timescale 1ns/10ps
`default_nettype none
`include "csf_defines.svh"
module csf_core #(
  parameter int CYC_W = 4
) (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst,
  // instruction request
  input  wire logic               opValid,
  input  wire csf_pkg::csf_op_type opCode,
  input  wire logic [CYC_W-1:0]   opCycles,
  input  wire logic [7:0]         opA,
  input  wire logic [7:0]         opB,
  input  wire csf_pkg::csf_speed_type speedMode,
  // register writes and direction read strobe
  input  wire logic               irqWrite,
  input  wire logic [7:0]         irqWriteData,
  input  wire logic               dirWrite,
  input  wire logic [7:0]         dirWriteData,
  input  wire logic               dirRead,
  // results
  output logic                    opBusy,
  output logic                    opDone,
  output logic [7:0]              resultLo,
  output logic [7:0]              resultHi,
  output logic [7:0]              processor_status_word,
  output logic [7:0]              irqVisible,
  output logic [7:0]              dirValue,
  output logic [7:0]              dirReadData
);
  csf_alu_if alu ();
  csf_addsub addsubUnit (.alu(alu));

  logic [1:0]       sysDiv;
  logic             sysTick;
  logic [CYC_W-1:0] cycLeft;
  csf_pkg::csf_op_type curOp;
  logic [7:0]       curA;
  logic [7:0]       curB;
  logic [7:0]       irqPending;
  logic             irqArmed;
  logic [15:0]      mulProd;

  // system clock enable: full rate in high speed, quarter in middle speed [RQ11]
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sysDiv <= 2'b00;
    end else begin
      sysDiv <= sysDiv + 2'b01;
    end
  end
  assign sysTick = (speedMode == csf_pkg::CSF_SPD_HIGH) || (sysDiv == 2'(`CSF_DIV_MID - 1));

  // operand routing to add/subtract unit
  assign alu.isSub       = (curOp == csf_pkg::CSF_OP_SUBC);
  assign alu.decimalMode = processor_status_word[`CSF_FLAG_D];
  assign alu.opA         = curA;
  assign alu.opB         = curB;
  assign alu.carryIn     = processor_status_word[`CSF_FLAG_C];
  assign mulProd         = curA * curB;

  // instruction timing: count system cycles [RQ11]
  always_ff @(posedge core_clk) begin
    if (rst) begin
      opBusy  <= 1'b0;
      opDone  <= 1'b0;
      cycLeft <= '0;
      curOp   <= csf_pkg::CSF_OP_NONE;
      curA    <= 8'h00;
      curB    <= 8'h00;
    end else begin
      opDone <= 1'b0;
      if (!opBusy && opValid) begin
        opBusy  <= 1'b1;
        cycLeft <= (opCycles == '0) ? CYC_W'(1) : opCycles;
        curOp   <= opCode;
        curA    <= opA;
        curB    <= opB;
      end else if (opBusy && sysTick) begin
        cycLeft <= cycLeft - CYC_W'(1);
        if (cycLeft == CYC_W'(1)) begin
          opBusy <= 1'b0;
          opDone <= 1'b1;
        end
      end
    end
  end

  // status word updates at instruction end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      processor_status_word <= `CSF_STATUS_RESET; // [RQ1]
    end else if (opBusy && sysTick && cycLeft == CYC_W'(1)) begin
      case (curOp)
        csf_pkg::CSF_OP_ADC, csf_pkg::CSF_OP_SUBC: begin
          processor_status_word[`CSF_FLAG_C] <= alu.carryOut; // [RQ4] [RQ12]
          processor_status_word[`CSF_FLAG_V] <= alu.overflow; // [RQ6]
          processor_status_word[`CSF_FLAG_N] <= alu.result[7];
          processor_status_word[`CSF_FLAG_Z] <= (alu.result == 8'h00);
        end
        csf_pkg::CSF_OP_SETC: processor_status_word[`CSF_FLAG_C] <= 1'b1;
        csf_pkg::CSF_OP_CLRC: processor_status_word[`CSF_FLAG_C] <= 1'b0;
        csf_pkg::CSF_OP_CLRD: processor_status_word[`CSF_FLAG_D] <= 1'b0;
        csf_pkg::CSF_OP_SED:  processor_status_word[`CSF_FLAG_D] <= 1'b1;
        csf_pkg::CSF_OP_SET:  processor_status_word[`CSF_FLAG_T] <= 1'b1;
        csf_pkg::CSF_OP_CLT:  processor_status_word[`CSF_FLAG_T] <= 1'b0;
        csf_pkg::CSF_OP_SETT: processor_status_word[`CSF_FLAG_T] <= 1'b1;
        default: ; // multiply/divide keep flags [RQ8]
      endcase
    end
  end

  // results; multiply and divide are flag-independent [RQ7]
  always_ff @(posedge core_clk) begin
    if (rst) begin
      resultLo <= 8'h00;
      resultHi <= 8'h00;
    end else if (opBusy && sysTick && cycLeft == CYC_W'(1)) begin
      case (curOp)
        csf_pkg::CSF_OP_ADC, csf_pkg::CSF_OP_SUBC: begin
          resultLo <= alu.result;
          resultHi <= 8'h00;
        end
        csf_pkg::CSF_OP_MULT: begin
          resultLo <= mulProd[7:0];
          resultHi <= mulProd[15:8];
        end
        csf_pkg::CSF_OP_DIV: begin
          resultLo <= (curB == 8'h00) ? 8'hFF : curA / curB;
          resultHi <= (curB == 8'h00) ? curA : curA % curB;
        end
        default: ;
      endcase
    end
  end

  // request bits appear only once the next instruction completes [RQ3]
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irqPending <= `CSF_IRQ_RESET;
      irqArmed   <= 1'b0;
      irqVisible <= `CSF_IRQ_RESET;
    end else if (irqWrite) begin
      irqPending <= irqWriteData;
      irqArmed   <= 1'b1;
    end else if (irqArmed && opDone) begin
      irqVisible <= irqPending; // [RQ3]
      irqArmed   <= 1'b0;
    end
  end

  // direction register: write-only, reads give zero [RQ9]
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dirValue    <= `CSF_DIR_RESET;
      dirReadData <= 8'h00;
    end else begin
      dirReadData <= 8'h00; // [RQ9]
      if (dirWrite) begin
        dirValue <= dirWriteData;
      end
    end
  end

  // checks
  mult_keeps_status_a: assert property (@(posedge core_clk) disable iff (rst)
    (opBusy && sysTick && cycLeft == CYC_W'(1) &&
     (curOp == csf_pkg::CSF_OP_MULT || curOp == csf_pkg::CSF_OP_DIV))
    |=> $stable(processor_status_word)) else $error("status changed by multiply/divide"); // [RQ8]
  reset_sets_i_a: assert property (@(posedge core_clk)
    rst |=> processor_status_word[`CSF_FLAG_I]) else $error("i flag not set at reset"); // [RQ1]
  mult_product_a: assert property (@(posedge core_clk) disable iff (rst)
    (opBusy && sysTick && cycLeft == CYC_W'(1) && curOp == csf_pkg::CSF_OP_MULT)
    |=> {resultHi, resultLo} == $past(mulProd)) else $error("bad product"); // [RQ7]
  bin_add_a: assert property (@(posedge core_clk) disable iff (rst)
    (opBusy && sysTick && cycLeft == CYC_W'(1) && curOp == csf_pkg::CSF_OP_ADC &&
     !processor_status_word[`CSF_FLAG_D])
    |=> resultLo == 8'($past(curA) + $past(curB) + {7'h0, $past(alu.carryIn)}))
    else $error("binary add wrong"); // [RQ12]
  irq_delay_a: assert property (@(posedge core_clk) disable iff (rst)
    irqWrite && !irqArmed && !opDone |=> irqVisible == $past(irqVisible))
    else $error("request bits changed at once"); // [RQ3]
  dir_read_zero_a: assert property (@(posedge core_clk) disable iff (rst)
    dirRead |=> dirReadData == 8'h00) else $error("direction read not zero"); // [RQ9]
  high_speed_a: assert property (@(posedge core_clk) disable iff (rst)
    (!opBusy && opValid && opCycles == CYC_W'(2) && speedMode == csf_pkg::CSF_SPD_HIGH)
    ##1 (speedMode == csf_pkg::CSF_SPD_HIGH)[*2] |=> opDone)
    else $error("high speed timing wrong"); // [RQ11]
  i_kept_a: assert property (@(posedge core_clk) disable iff (rst)
    opDone |-> processor_status_word[`CSF_FLAG_I] == $past(processor_status_word[`CSF_FLAG_I]))
    else $error("i flag changed by op"); // [RQ1]
  cov_mult_c: cover property (@(posedge core_clk) opDone && curOp == csf_pkg::CSF_OP_MULT);
  cov_dec_c: cover property (@(posedge core_clk)
    opDone && curOp == csf_pkg::CSF_OP_ADC && processor_status_word[`CSF_FLAG_D]);
  cov_irq_c: cover property (@(posedge core_clk) irqArmed && opDone);
endmodule : csf_core
`default_nettype wire

// file: verilog/csf_defines.svh
// Purpose: constants for the status flag and arithmetic core
// Assumes: 8-bit data path, one core clock
// Notes:   flag positions follow a conventional status byte layout
`ifndef CSF_DEFINES_SVH
`define CSF_DEFINES_SVH
`define CSF_FLAG_C      0
`define CSF_FLAG_Z      1
`define CSF_FLAG_I      2
`define CSF_FLAG_D      3
`define CSF_FLAG_B      4
`define CSF_FLAG_T      5
`define CSF_FLAG_V      6
`define CSF_FLAG_N      7
`define CSF_STATUS_RESET 8'h04
`define CSF_IRQ_RESET   8'h00
`define CSF_DIR_RESET   8'h00
`define CSF_IRQ_LAT     2
`define CSF_DIV_MID     4
`define CSF_BCD_ADJ     8'h06
`define CSF_BCD_ADJ_HI  8'h60
`endif

// file: verilog/csf_pkg.sv
// Purpose: types for the status flag and arithmetic core
// Assumes: nothing included; operation and speed codes are literals here
// Notes:   operation codes are this block's own encoding
package csf_pkg;
  typedef enum logic [3:0] {
    CSF_OP_NONE = 4'b0000,
    CSF_OP_ADC  = 4'b0001,
    CSF_OP_SUBC = 4'b0010,
    CSF_OP_SETC = 4'b0011,
    CSF_OP_CLRC = 4'b0100,
    CSF_OP_CLRD = 4'b0101,
    CSF_OP_SED  = 4'b0110,
    CSF_OP_MULT = 4'b0111,
    CSF_OP_DIV  = 4'b1000,
    CSF_OP_SET  = 4'b1001,
    CSF_OP_CLT  = 4'b1010,
    CSF_OP_SETT = 4'b1011
  } csf_op_type;
  typedef enum logic [1:0] {
    CSF_SPD_MID  = 2'b00,
    CSF_SPD_HIGH = 2'b01
  } csf_speed_type;
endpackage : csf_pkg
